// file: fppc_pkg.sv
// Functional notes
// R1 - power press only requests, never switches supply
// R2 - press or wake while off starts power-up
// R3 - power-up drives power-good and reset, then ON
// R4 - drop supply request when chipset reports off
// R5 - force off if press unserviced in time; with an ACPI OS active no forced off
// R6 - firmware without OS masks SCI, uses SMI
// R7 - with ACPI OS, press raises SCI request
// R8 - reset press forwarded, independent of firmware
// R9 - identify press inverts identify LED
// R10 - identify LED holds until press or command
// R11 - power LED lit exactly while DC on
// R12 - ACPI: S5 off, S1 blink 1 Hz, S0 on
// R13 - buttons synchronised and debounced, one action
package fppc_pkg;
	localparam int unsigned CLK_HZ = 20000000;
	// debounce settle time
	localparam int unsigned DEBOUNCE_MS = 20;
	localparam int unsigned DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
	// forced off between four and five seconds: pick 4.5 s
	localparam int unsigned FORCE_OFF_MS = 4500;
	localparam int unsigned FORCE_OFF_CYC = CLK_HZ / 1000 * FORCE_OFF_MS;
	// supply settle before power-good
	localparam int unsigned PGOOD_DELAY_MS = 100;
	localparam int unsigned PGOOD_DELAY_CYC = CLK_HZ / 1000 * PGOOD_DELAY_MS;
	// reset held after power-good
	localparam int unsigned RESET_HOLD_MS = 10;
	localparam int unsigned RESET_HOLD_CYC = CLK_HZ / 1000 * RESET_HOLD_MS;
	// half period of ~1 Hz blink
	localparam int unsigned BLINK_HALF_MS = 500;
	localparam int unsigned BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
	// request pulse width to the chipset
	localparam int unsigned REQ_PULSE_CYC = 1;
	// acpi sleep state encoding
	localparam logic [1:0] SLP_S0 = 2'h0;
	localparam logic [1:0] SLP_S1 = 2'h1;
	localparam logic [1:0] SLP_S5 = 2'h3;
	typedef enum logic [1:0] {
		FPPC_OFF = 2'h0,
		FPPC_SUPPLY = 2'h1,
		FPPC_RESET = 2'h3,
		FPPC_ON = 2'h2
	} fppc_state_t;
endpackage

// file: fppc_top.sv
`timescale 1ns/1ns
module fppc_top #(
	parameter int unsigned DEBOUNCE_CYC = fppc_pkg::DEBOUNCE_CYC,
	parameter int unsigned FORCE_OFF_CYC = fppc_pkg::FORCE_OFF_CYC,
	parameter int unsigned PGOOD_DELAY_CYC = fppc_pkg::PGOOD_DELAY_CYC,
	parameter int unsigned RESET_HOLD_CYC = fppc_pkg::RESET_HOLD_CYC,
	parameter int unsigned BLINK_HALF_CYC = fppc_pkg::BLINK_HALF_CYC
) (
	// clock, reset, enable
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// front panel buttons, active low, asynchronous
	input wire logic panel_power_press_n,
	input wire logic panel_reset_press_n,
	input wire logic panel_identify_press_n,
	// chipset status, asynchronous
	input wire logic chipset_wake,
	input wire logic chipset_off,
	input wire logic [1:0] acpi_sleep_state,
	input wire logic acpi_os_active,
	// identify command from management firmware, same clock
	input wire logic identify_cmd_valid,
	input wire logic identify_cmd_on,
	// requests to chipset
	output logic power_button_req,
	output logic sci_req,
	output logic reset_req,
	// power sequencing
	output logic supply_on_request,
	output logic power_good,
	output logic board_reset_n,
	// lamps, active low
	output logic identify_lamp_n,
	output logic power_lamp_n
);
	localparam int CW = 32;
	localparam logic [CW-1:0] ONE = 32'h00000001;

	// last cycle of an interval; a zero length wraps to the longest interval
	function automatic logic cnt_done(input logic [CW-1:0] cnt,
		input logic [CW-1:0] len);
		return cnt >= len - ONE;
	endfunction

	// two-stage synchronisers for all asynchronous inputs
	logic [6:0] sync_a;
	logic [6:0] sync_b;
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sync_a <= 7'h07;
			sync_b <= 7'h07;
		end else if (clk_en) begin
			sync_a <= {acpi_os_active, acpi_sleep_state, chipset_off,
				panel_identify_press_n, panel_reset_press_n,
				panel_power_press_n}; // [R13]
			sync_b <= sync_a;
		end
	end
	logic os_s;
	logic [1:0] slp_s;
	logic off_s;
	assign os_s = sync_b[6];
	assign slp_s = sync_b[5:4];
	assign off_s = sync_b[3];

	// wake line: separate sync, edge detected after second stage
	logic wake_a;
	logic wake_b;
	logic wake_d;
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wake_a <= 1'b0;
			wake_b <= 1'b0;
			wake_d <= 1'b0;
		end else if (clk_en) begin
			wake_a <= chipset_wake;
			wake_b <= wake_a;
			wake_d <= wake_b;
		end
	end
	logic wake_edge;
	assign wake_edge = wake_b & ~wake_d; // [R2]

	// debounce: a level must hold DEBOUNCE_CYC before it is accepted
	logic [2:0] btn_stable;
	logic [2:0] btn_press;
	logic [CW-1:0] db_cnt [3];
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			btn_stable <= 3'h0;
			btn_press <= 3'h0;
			for (int i = 0; i < 3; i++) begin
				db_cnt[i] <= '0;
			end
		end else if (clk_en) begin
			for (int i = 0; i < 3; i++) begin
				btn_press[i] <= 1'b0;
				if (~sync_b[i] == btn_stable[i]) begin
					db_cnt[i] <= '0;
				end else if (cnt_done(db_cnt[i],
					DEBOUNCE_CYC[CW-1:0])) begin
					db_cnt[i] <= '0;
					btn_stable[i] <= ~sync_b[i];
					// one pulse per accepted press edge only
					btn_press[i] <= ~sync_b[i]; // [R13]
				end else begin
					db_cnt[i] <= db_cnt[i] + ONE;
				end
			end
		end
	end
	logic pwr_press;
	logic rst_press;
	logic id_press;
	assign pwr_press = btn_press[0];
	assign rst_press = btn_press[1];
	assign id_press = btn_press[2];

	// power sequencer; the button never touches the supply directly
	fppc_pkg::fppc_state_t state;
	logic [CW-1:0] seq_cnt;
	logic [CW-1:0] force_cnt;
	logic force_arm;
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state <= fppc_pkg::FPPC_OFF;
			seq_cnt <= '0;
		end else if (clk_en) begin
			case (state)
				fppc_pkg::FPPC_OFF: begin
					seq_cnt <= '0;
					if (pwr_press | wake_edge) begin
						state <= fppc_pkg::FPPC_SUPPLY; // [R2]
					end
				end
				fppc_pkg::FPPC_SUPPLY: begin
					if (cnt_done(seq_cnt, PGOOD_DELAY_CYC[CW-1:0])) begin
						seq_cnt <= '0;
						state <= fppc_pkg::FPPC_RESET; // [R3]
					end else begin
						seq_cnt <= seq_cnt + ONE;
					end
				end
				fppc_pkg::FPPC_RESET: begin
					if (cnt_done(seq_cnt, RESET_HOLD_CYC[CW-1:0])) begin
						seq_cnt <= '0;
						state <= fppc_pkg::FPPC_ON; // [R3]
					end else begin
						seq_cnt <= seq_cnt + ONE;
					end
				end
				fppc_pkg::FPPC_ON: begin
					// chipset reached off, or firmware never answered
					if (off_s | (force_arm &&
						cnt_done(force_cnt, FORCE_OFF_CYC[CW-1:0]))) begin
						state <= fppc_pkg::FPPC_OFF; // [R4] [R5]
					end
				end
				default: state <= fppc_pkg::FPPC_OFF;
			endcase
		end
	end

	// forced-off watchdog, armed by a press while on without an OS
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			force_arm <= 1'b0;
			force_cnt <= '0;
		end else if (clk_en) begin
			if (state != fppc_pkg::FPPC_ON) begin
				force_arm <= 1'b0;
				force_cnt <= '0;
			end else if (pwr_press & ~force_arm) begin
				// an OS may legitimately sleep instead; watchdog covers
				// only firmware without an OS servicing the SMI
				force_arm <= ~os_s; // [R5] [R6]
				force_cnt <= '0;
			end else if (force_arm) begin
				force_cnt <= force_cnt + ONE; // [R5]
			end
		end
	end

	// supply request follows every state but off
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			supply_on_request <= 1'b0;
		end else if (clk_en) begin
			supply_on_request <= (state != fppc_pkg::FPPC_OFF); // [R4]
		end
	end

	// power good leads reset release by the whole hold time
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			power_good <= 1'b0;
		end else if (clk_en) begin
			power_good <= (state == fppc_pkg::FPPC_RESET) |
				(state == fppc_pkg::FPPC_ON); // [R3]
		end
	end

	// board leaves reset only in the on state
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			board_reset_n <= 1'b0;
		end else if (clk_en) begin
			board_reset_n <= (state == fppc_pkg::FPPC_ON); // [R3]
		end
	end

	// power request goes to the chipset, never to the supply
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			power_button_req <= 1'b0;
		end else if (clk_en) begin
			power_button_req <= pwr_press &
				(state == fppc_pkg::FPPC_ON); // [R1]
		end
	end

	// sci only while an os is there to take it
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sci_req <= 1'b0;
		end else if (clk_en) begin
			sci_req <= pwr_press & os_s &
				(state == fppc_pkg::FPPC_ON); // [R7]
		end
	end

	// no firmware gate on the reset path
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			reset_req <= 1'b0;
		end else if (clk_en) begin
			reset_req <= rst_press &
				(state == fppc_pkg::FPPC_ON); // [R8]
		end
	end

	// identify lamp: press toggles, command loads identify_cmd_on; press wins ties
	logic id_lit;
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			id_lit <= 1'b0;
		end else if (clk_en) begin
			if (id_press) begin
				id_lit <= ~id_lit; // [R9]
			end else if (identify_cmd_valid) begin
				id_lit <= identify_cmd_on; // [R10]
			end
		end
	end

	// ~1 Hz blink generator
	logic [CW-1:0] blink_cnt;
	logic blink;
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			blink_cnt <= '0;
			blink <= 1'b0;
		end else if (clk_en) begin
			if (cnt_done(blink_cnt, BLINK_HALF_CYC[CW-1:0])) begin
				blink_cnt <= '0;
				blink <= ~blink; // [R12]
			end else begin
				blink_cnt <= blink_cnt + ONE;
			end
		end
	end

	// lamp drive, active low
	logic pwr_lit;
	always_comb begin
		pwr_lit = 1'b0;
		if (supply_on_request) begin
			pwr_lit = 1'b1; // [R11]
			if (os_s) begin
				case (slp_s)
					fppc_pkg::SLP_S5: pwr_lit = 1'b0; // [R12]
					fppc_pkg::SLP_S1: pwr_lit = blink; // [R12]
					fppc_pkg::SLP_S0: pwr_lit = 1'b1; // [R12]
					default: pwr_lit = 1'b1;
				endcase
			end
		end
	end

	// identify lamp pin, dark out of reset
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			identify_lamp_n <= 1'b1;
		end else if (clk_en) begin
			identify_lamp_n <= ~id_lit;
		end
	end

	// power lamp pin, flopped so the blink has no glitches
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			power_lamp_n <= 1'b1;
		end else if (clk_en) begin
			power_lamp_n <= ~pwr_lit;
		end
	end
endmodule

// file: fppc_chipset_model.sv
`timescale 1ns/1ns
module fppc_chipset_model (
	// clock, firmware servicing switch
	input wire logic ref_clk,
	input wire logic serve,
	// from the block
	input wire logic power_button_req,
	input wire logic supply_on_request,
	// to the block
	output logic chipset_off
);
	// chipset sits in off while unpowered; firmware turns it off on a press
	always @(posedge ref_clk) begin
		if (!supply_on_request)
			chipset_off <= 1'h1;
		else if (power_button_req && serve)
			chipset_off <= 1'h1;
		else if ($rose(supply_on_request))
			chipset_off <= 1'h0;
	end
endmodule

// file: fppc_checker.sv
`timescale 1ns/1ns
module fppc_checker (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// watched ports
	input wire logic identify_cmd_valid,
	input wire logic identify_cmd_on,
	input wire logic chipset_off,
	input wire logic power_button_req,
	input wire logic sci_req,
	input wire logic reset_req,
	input wire logic supply_on_request,
	input wire logic power_good,
	input wire logic board_reset_n,
	input wire logic identify_lamp_n,
	input wire logic power_lamp_n
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	pg_supply_a: assert property (power_good |-> supply_on_request)
		else $error("power good without supply");
	run_order_a: assert property (board_reset_n |-> power_good)
		else $error("reset released without power good");
	run_hold_a: assert property ($rose(board_reset_n) |->
		$past(power_good, 4))
		else $error("reset released too early");
	lamp_dark_a: assert property ((!supply_on_request)[*3] |->
		power_lamp_n)
		else $error("power lamp lit while off");
	press_pulse_a: assert property (power_button_req && clk_en |=>
		!power_button_req)
		else $error("power request longer than one cycle");
	reset_pulse_a: assert property (reset_req && clk_en |=>
		!reset_req)
		else $error("reset request longer than one cycle");
	sci_gate_a: assert property (sci_req |-> power_button_req)
		else $error("sci request without a forwarded press");
	chip_off_a: assert property ((chipset_off && board_reset_n)[*4] |->
		##[0:4] !supply_on_request)
		else $error("supply kept on after chipset off");
	id_cmd_a: assert property (identify_cmd_valid && clk_en ##1 clk_en |=>
		identify_lamp_n != $past(identify_cmd_on, 2))
		else $error("identify command not applied");
	cover property (power_good);
	cover property (reset_req);
	cover property (!power_lamp_n && supply_on_request ##1 power_lamp_n);
endmodule
bind fppc_top fppc_checker fppc_checker_i (.ref_clk, .sys_rst, .clk_en,
	.identify_cmd_valid, .identify_cmd_on, .chipset_off, .power_button_req,
	.sci_req, .reset_req, .supply_on_request, .power_good, .board_reset_n,
	.identify_lamp_n, .power_lamp_n);

// file: fppc_top_test.sv
`timescale 1ns/1ns
module fppc_top_test;
	logic ref_clk = 0;
	logic sys_rst = 1;
	logic [2:0] btn_n = 3'h7;
	logic chipset_wake = 0;
	logic chipset_off;
	logic [1:0] acpi_sleep_state = 2'h0;
	logic acpi_os_active = 0;
	logic identify_cmd_valid = 0;
	logic identify_cmd_on = 0;
	logic serve = 0;
	logic clk_en = 1;
	logic power_button_req, sci_req, reset_req, supply_on_request;
	logic power_good, board_reset_n, identify_lamp_n, power_lamp_n;
	int failures = 0;
	int n_compared = 0;
	int n_pb = 0;
	int n_sci = 0;
	int n_rst = 0;
	// 20 MHz
	always #25 ref_clk = ~ref_clk;
	// request pulses last one cycle, so tally them on every edge
	always @(posedge ref_clk) begin
		n_pb += power_button_req;
		n_sci += sci_req;
		n_rst += reset_req;
	end
	fppc_top #(.DEBOUNCE_CYC(4), .FORCE_OFF_CYC(50), .PGOOD_DELAY_CYC(5),
		.RESET_HOLD_CYC(5), .BLINK_HALF_CYC(8)) fppc_top_i (.ref_clk,
		.sys_rst, .clk_en, .panel_power_press_n(btn_n[0]),
		.panel_reset_press_n(btn_n[1]), .panel_identify_press_n(btn_n[2]),
		.chipset_wake, .chipset_off, .acpi_sleep_state, .acpi_os_active,
		.identify_cmd_valid, .identify_cmd_on, .power_button_req, .sci_req,
		.reset_req, .supply_on_request, .power_good, .board_reset_n,
		.identify_lamp_n, .power_lamp_n);
	fppc_chipset_model fppc_chipset_model_i (.ref_clk, .serve,
		.power_button_req, .supply_on_request, .chipset_off);
	task step(input int n);
		repeat (n) @(posedge ref_clk);
		#5;
	endtask
	task check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// long enough to outlast the debounce on press and release
	task press(input int b);
		btn_n[b] = 0;
		step(10);
		btn_n[b] = 1;
		step(10);
	endtask
	task end_of_test;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task wait_sup(input logic v);
		int i;
		for (i = 0; i < 90 && supply_on_request !== v; i++)
			step(1);
		if (i == 90) begin
			failures++;
			end_of_test;
		end
	endtask
	task test_power_on;
		// off: press starts power-up, no request forwarded
		press(0);
		check(n_pb[7:0], 8'h00);
		wait_sup(1);
		check(supply_on_request, 8'h01);
		step(20);
		check(power_good, 8'h01);
		check(board_reset_n, 8'h01);
		check(power_lamp_n, 8'h00);
		$display("power on done");
	endtask
	task test_acpi;
		int dark;
		// acpi os: reset and sci requests, lamp by sleep state
		acpi_os_active = 1;
		press(1);
		check(n_rst[7:0], 8'h01);
		// a glitch shorter than the debounce time is dropped
		btn_n[1] = 0;
		step(2);
		btn_n[1] = 1;
		step(10);
		check(n_rst[7:0], 8'h01);
		press(0);
		check(n_sci[7:0], 8'h01);
		check(n_pb[7:0], 8'h01);
		step(60);
		check(supply_on_request, 8'h01);
		acpi_sleep_state = 2'h1;
		step(4);
		dark = 0;
		repeat (32) begin
			step(1);
			dark += power_lamp_n;
		end
		check(dark[7:0], 8'h10);
		acpi_sleep_state = 2'h3;
		step(6);
		check(power_lamp_n, 8'h01);
		acpi_sleep_state = 2'h2;
		step(6);
		check(power_lamp_n, 8'h00);
		acpi_sleep_state = 2'h0;
		step(6);
		check(power_lamp_n, 8'h00);
		acpi_os_active = 0;
		$display("acpi done");
	endtask
	task test_serviced_off;
		// firmware services the press, chipset goes off
		serve = 1;
		press(0);
		wait_sup(0);
		check(supply_on_request, 8'h00);
		step(3);
		check(power_good, 8'h00);
		check(board_reset_n, 8'h00);
		check(power_lamp_n, 8'h01);
		serve = 0;
		$display("serviced off done");
	endtask
	task test_forced_off;
		// wake from off, then an unserviced press forces off
		chipset_wake = 1;
		step(4);
		chipset_wake = 0;
		wait_sup(1);
		check(supply_on_request, 8'h01);
		step(20);
		check(board_reset_n, 8'h01);
		press(0);
		check(supply_on_request, 8'h01);
		wait_sup(0);
		check(supply_on_request, 8'h00);
		$display("forced off done");
	endtask
	task test_identify;
		// identify lamp toggles and obeys commands both ways
		check(identify_lamp_n, 8'h01);
		press(2);
		check(identify_lamp_n, 8'h00);
		step(30);
		check(identify_lamp_n, 8'h00);
		press(2);
		check(identify_lamp_n, 8'h01);
		identify_cmd_on = 1;
		identify_cmd_valid = 1;
		step(1);
		identify_cmd_valid = 0;
		step(2);
		check(identify_lamp_n, 8'h00);
		identify_cmd_on = 0;
		identify_cmd_valid = 1;
		step(1);
		identify_cmd_valid = 0;
		step(2);
		check(identify_lamp_n, 8'h01);
		$display("identify done");
	endtask
	task test_freeze;
		// with the enable low a press is never seen
		clk_en = 0;
		press(2);
		check(identify_lamp_n, 8'h01);
		clk_en = 1;
		step(10);
		check(identify_lamp_n, 8'h01);
		press(2);
		check(identify_lamp_n, 8'h00);
		$display("freeze done");
	endtask
	initial begin
		step(4);
		sys_rst = 0;
		test_power_on;
		test_acpi;
		test_serviced_off;
		test_forced_off;
		test_identify;
		test_freeze;
		end_of_test;
	end
endmodule
